// ---- common/dnbs_pkg.sv ----
// shared constants for the per-channel oscillator bank and its synchronization
package dnbs_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int NUM_CHAN = 2;
    localparam int NUM_OSC = 4;
    localparam int SEL_W = 2;
    localparam int FREQ_W = 32;
    localparam int PHASE_W = 16;
    localparam int RDIV_W = 16;
    localparam int PROD_W = FREQ_W + RDIV_W;
    localparam int REM_W = RDIV_W + 2;

    // ----------------------------------------------------------------
    // rational mode: 2^32 / 64 = 2^26
    // ----------------------------------------------------------------
    localparam int RAT_SHIFT = 26;
    localparam logic [PROD_W:0] RAT_HALF = 49'h0_0000_0200_0000;
    localparam logic [RDIV_W-1:0] RDIV_BASIC = 16'h0000;
    localparam int RDIV_MAX_ADVISED = 8192;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [FREQ_W-1:0] ACC_RESET = 32'h0000_0000;
    localparam logic [RDIV_W-1:0] FRAC_RESET = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;

    // ----------------------------------------------------------------
    // timing at the 40 MHz device clock
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SYNC_STAGES = 2;
    localparam int PIN_TO_MIXER_MIN_CYC = 36;
    localparam int PIN_TO_MIXER_MAX_CYC = 40;
    localparam int SEL_DELAY_CYC = PIN_TO_MIXER_MIN_CYC - SYNC_STAGES;

    // ----------------------------------------------------------------
    // asynchronous input vector positions
    // ----------------------------------------------------------------
    localparam int ASYNC_W = 7;
    localparam int AIX_PINS_A = 0;
    localparam int AIX_PINS_B = 2;
    localparam int AIX_SYNC_SE = 4;
    localparam int AIX_SYNC_DIFF = 5;
    localparam int AIX_SYSREF = 6;

    // link synchronization sequencer
    typedef enum logic [2:0] {
        DNBS_LINK_IDLE = 3'b001,
        DNBS_LINK_CGS = 3'b010,
        DNBS_LINK_DONE = 3'b100
    } dnbs_link_st_t;

endpackage

// ---- hw/dnbs_phase_acc.sv ----
// one phase accumulator with offset and rational remainder carry
`timescale 1ns/1ps
`default_nettype none

module dnbs_phase_acc (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // settings
    input wire logic [dnbs_pkg::FREQ_W-1:0] freq_word_in,
    input wire logic [dnbs_pkg::PHASE_W-1:0] phase_offset_in,
    input wire logic [dnbs_pkg::RDIV_W-1:0] rational_step_divisor_in,
    // control
    input wire logic sync_in,
    // result
    output logic [dnbs_pkg::FREQ_W-1:0] phase_out
);

    logic [dnbs_pkg::FREQ_W-1:0] acc;
    logic [dnbs_pkg::RDIV_W-1:0] frac;
    logic [dnbs_pkg::FREQ_W-1:0] next_acc;
    logic [dnbs_pkg::RDIV_W-1:0] next_frac;
    logic [dnbs_pkg::PROD_W-1:0] prod;
    logic [dnbs_pkg::PROD_W:0] prod_round;
    logic [dnbs_pkg::PROD_W:0] n_scaled;
    logic [dnbs_pkg::PROD_W:0] diff;
    logic signed [dnbs_pkg::REM_W-1:0] rem_step;
    logic signed [dnbs_pkg::REM_W-1:0] div_s;
    logic signed [dnbs_pkg::REM_W-1:0] sum;
    logic [dnbs_pkg::FREQ_W-1:0] carry;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        // word*div differs from 2^26*N by rem_step; N recovered by rounding
        prod = freq_word_in * rational_step_divisor_in;
        prod_round = {1'b0, prod} + dnbs_pkg::RAT_HALF;
        n_scaled = {prod_round[dnbs_pkg::PROD_W:dnbs_pkg::RAT_SHIFT], {dnbs_pkg::RAT_SHIFT{1'b0}}};
        diff = n_scaled - {1'b0, prod};
        rem_step = $signed(diff[dnbs_pkg::REM_W-1:0]);
        div_s = $signed({2'b00, rational_step_divisor_in});
        sum = $signed({2'b00, frac}) + rem_step;
        carry = dnbs_pkg::ACC_RESET;
        next_frac = frac;
        if (rational_step_divisor_in == dnbs_pkg::RDIV_BASIC)
        begin
            next_frac = dnbs_pkg::FRAC_RESET;
        end
        else if (sum >= div_s)
        begin
            next_frac = dnbs_pkg::RDIV_W'(sum - div_s);
            carry = 32'h0000_0001;
        end
        else if (sum < $signed(18'h0_0000))
        begin
            next_frac = dnbs_pkg::RDIV_W'(sum + div_s);
            carry = 32'hffff_ffff;
        end
        else
        begin
            next_frac = dnbs_pkg::RDIV_W'(sum);
        end
        // free running, wraps modulo 2^32
        next_acc = acc + freq_word_in + carry;
        if (sync_in)
        begin
            // only a sync restores a known phase after word changes
            next_acc = dnbs_pkg::ACC_RESET;
            next_frac = dnbs_pkg::FRAC_RESET;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            acc <= dnbs_pkg::ACC_RESET;
            frac <= dnbs_pkg::FRAC_RESET;
        end
        else
        begin
            acc <= next_acc;
            frac <= next_frac;
        end
    end

    // offset left-justified into the 32-bit phase
    assign phase_out = acc + {phase_offset_in, {(dnbs_pkg::FREQ_W - dnbs_pkg::PHASE_W){1'b0}}};

endmodule // dnbs_phase_acc

`default_nettype wire

// ---- hw/dnbs_nco_bank.sv ----
// two-channel oscillator bank with selection and phase synchronization
`timescale 1ns/1ps
`default_nettype none

module dnbs_nco_bank (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // oscillator selection
    input wire logic osc_select_source_in,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_a_osc_select_field_in,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_b_osc_select_field_in,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_a_osc_select_pins_in,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_b_osc_select_pins_in,
    // frequency and phase settings
    input wire logic [dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::FREQ_W-1:0] chan_a_freq_word_in,
    input wire logic [dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::FREQ_W-1:0] chan_b_freq_word_in,
    input wire logic [dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::PHASE_W-1:0] chan_a_phase_offset_in,
    input wire logic [dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::PHASE_W-1:0] chan_b_phase_offset_in,
    input wire logic [dnbs_pkg::RDIV_W-1:0] rational_step_divisor_in,
    // synchronization control
    input wire logic sync_on_link_init_in,
    input wire logic sync_on_next_sysref_arm_in,
    input wire logic serial_link_enable_in,
    input wire logic sync_input_is_differential_in,
    // synchronization pins
    input wire logic single_ended_sync_input_in,
    input wire logic differential_sync_input_in,
    input wire logic sysref_in,
    // oscillator outputs
    output logic [dnbs_pkg::FREQ_W-1:0] chan_a_phase_out,
    output logic [dnbs_pkg::FREQ_W-1:0] chan_b_phase_out,
    output logic [dnbs_pkg::SEL_W-1:0] chan_a_active_osc_out,
    output logic [dnbs_pkg::SEL_W-1:0] chan_b_active_osc_out,
    // synchronization status
    output logic nco_sync_out,
    output logic sync_armed_out
);

    // ----------------------------------------------------------------
    // selection decode
    // ----------------------------------------------------------------
    function automatic logic [dnbs_pkg::SEL_W-1:0] dnbs_pick_osc(
        input logic source,
        input logic [dnbs_pkg::SEL_W-1:0] pins,
        input logic [dnbs_pkg::SEL_W-1:0] field
    );
        logic [dnbs_pkg::SEL_W-1:0] pick;
        pick = field;
        if (source)
        begin
            pick = pins;
        end
        return pick;
    endfunction

    // ----------------------------------------------------------------
    // input synchronizers
    // ----------------------------------------------------------------
    logic [dnbs_pkg::ASYNC_W-1:0] async_raw;
    logic [dnbs_pkg::ASYNC_W-1:0] async_meta;
    logic [dnbs_pkg::ASYNC_W-1:0] async_stable;
    logic [dnbs_pkg::ASYNC_W-1:0] next_async_meta;
    logic [dnbs_pkg::ASYNC_W-1:0] next_async_stable;
    // sync pins rest high: no false low right after reset
    localparam logic [dnbs_pkg::ASYNC_W-1:0] ASYNC_IDLE = 7'h30;

    assign async_raw = {sysref_in, differential_sync_input_in, single_ended_sync_input_in,
                        chan_b_osc_select_pins_in, chan_a_osc_select_pins_in};

    always_comb
    begin
        next_async_meta = async_raw;
        next_async_stable = async_meta;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            async_meta <= ASYNC_IDLE;
            async_stable <= ASYNC_IDLE;
        end
        else
        begin
            async_meta <= next_async_meta;
            async_stable <= next_async_stable;
        end
    end

    // ----------------------------------------------------------------
    // select pin latency line
    // ----------------------------------------------------------------
    logic [dnbs_pkg::SEL_DELAY_CYC-1:0][dnbs_pkg::SEL_W-1:0] dly_a;
    logic [dnbs_pkg::SEL_DELAY_CYC-1:0][dnbs_pkg::SEL_W-1:0] dly_b;
    logic [dnbs_pkg::SEL_DELAY_CYC-1:0][dnbs_pkg::SEL_W-1:0] next_dly_a;
    logic [dnbs_pkg::SEL_DELAY_CYC-1:0][dnbs_pkg::SEL_W-1:0] next_dly_b;

    always_comb
    begin
        next_dly_a[0] = async_stable[dnbs_pkg::AIX_PINS_A +: dnbs_pkg::SEL_W];
        next_dly_b[0] = async_stable[dnbs_pkg::AIX_PINS_B +: dnbs_pkg::SEL_W];
        for (int i = 1; i < dnbs_pkg::SEL_DELAY_CYC; i++)
        begin
            next_dly_a[i] = dly_a[i-1];
            next_dly_b[i] = dly_b[i-1];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            dly_a <= '0;
            dly_b <= '0;
        end
        else
        begin
            dly_a <= next_dly_a;
            dly_b <= next_dly_b;
        end
    end

    // ----------------------------------------------------------------
    // link and sysref synchronization
    // ----------------------------------------------------------------
    logic link_sync_lvl;
    logic sysref_lvl;
    logic sysref_prev;
    logic arm_prev;
    logic armed;
    logic sync_pulse;
    logic sync_now;
    logic sysref_rise;
    logic arm_rise;
    logic next_sysref_prev;
    logic next_arm_prev;
    logic next_armed;
    logic next_sync_pulse;
    dnbs_pkg::dnbs_link_st_t link_st;
    dnbs_pkg::dnbs_link_st_t next_link_st;

    assign link_sync_lvl = sync_input_is_differential_in ? async_stable[dnbs_pkg::AIX_SYNC_DIFF]
                                                         : async_stable[dnbs_pkg::AIX_SYNC_SE];
    assign sysref_lvl = async_stable[dnbs_pkg::AIX_SYSREF];
    assign sysref_rise = sysref_lvl & ~sysref_prev;
    assign arm_rise = sync_on_next_sysref_arm_in & ~arm_prev;

    always_comb
    begin
        next_link_st = link_st;
        sync_now = 1'b0;
        case (link_st)
            dnbs_pkg::DNBS_LINK_IDLE:
            begin
                // receiver pulls SYNC low to start code group sync
                if (sync_on_link_init_in && serial_link_enable_in && !link_sync_lvl)
                begin
                    next_link_st = dnbs_pkg::DNBS_LINK_CGS;
                end
            end
            dnbs_pkg::DNBS_LINK_CGS:
            begin
                if (!serial_link_enable_in)
                begin
                    next_link_st = dnbs_pkg::DNBS_LINK_IDLE;
                end
                else if (link_sync_lvl)
                begin
                    // release of SYNC aligns the oscillators
                    sync_now = sync_on_link_init_in;
                    next_link_st = dnbs_pkg::DNBS_LINK_DONE;
                end
            end
            dnbs_pkg::DNBS_LINK_DONE:
            begin
                // wait for the link to be disabled and restarted
                if (!serial_link_enable_in)
                begin
                    next_link_st = dnbs_pkg::DNBS_LINK_IDLE;
                end
            end
            default:
            begin
                next_link_st = dnbs_pkg::DNBS_LINK_IDLE;
            end
        endcase
        next_armed = armed;
        if (armed && sysref_rise && !sync_on_link_init_in)
        begin
            sync_now = 1'b1;
            next_armed = 1'b0;
        end
        // a new arming write wins over consumption in the same cycle
        if (arm_rise)
        begin
            next_armed = 1'b1;
        end
        next_sysref_prev = sysref_lvl;
        next_arm_prev = sync_on_next_sysref_arm_in;
        next_sync_pulse = sync_now;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            link_st <= dnbs_pkg::DNBS_LINK_IDLE;
            sysref_prev <= 1'b0;
            arm_prev <= 1'b0;
            armed <= 1'b0;
            sync_pulse <= 1'b0;
        end
        else
        begin
            link_st <= next_link_st;
            sysref_prev <= next_sysref_prev;
            arm_prev <= next_arm_prev;
            armed <= next_armed;
            sync_pulse <= next_sync_pulse;
        end
    end

    // ----------------------------------------------------------------
    // accumulator bank
    // ----------------------------------------------------------------
    logic [dnbs_pkg::NUM_CHAN-1:0][dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::FREQ_W-1:0] freq_words;
    logic [dnbs_pkg::NUM_CHAN-1:0][dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::PHASE_W-1:0] phase_offsets;
    logic [dnbs_pkg::NUM_CHAN-1:0][dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::FREQ_W-1:0] acc_phase;

    assign freq_words = {chan_b_freq_word_in, chan_a_freq_word_in};
    assign phase_offsets = {chan_b_phase_offset_in, chan_a_phase_offset_in};

    generate
        for (genvar ch = 0; ch < dnbs_pkg::NUM_CHAN; ch++)
        begin : g_chan
            for (genvar osc = 0; osc < dnbs_pkg::NUM_OSC; osc++)
            begin : g_osc
                // each oscillator keeps its own word, offset and accumulator
                dnbs_phase_acc u_acc (
                    .sys_clk_in(sys_clk_in),
                    .nrst_in(nrst_in),
                    .freq_word_in(freq_words[ch][osc]),
                    .phase_offset_in(phase_offsets[ch][osc]),
                    .rational_step_divisor_in(rational_step_divisor_in),
                    .sync_in(sync_pulse),
                    .phase_out(acc_phase[ch][osc])
                );
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // output selection
    // ----------------------------------------------------------------
    logic [dnbs_pkg::SEL_W-1:0] sel_a;
    logic [dnbs_pkg::SEL_W-1:0] sel_b;
    logic [dnbs_pkg::FREQ_W-1:0] next_phase_a;
    logic [dnbs_pkg::FREQ_W-1:0] next_phase_b;

    always_comb
    begin
        sel_a = dnbs_pick_osc(osc_select_source_in, dly_a[dnbs_pkg::SEL_DELAY_CYC-1],
                              chan_a_osc_select_field_in);
        sel_b = dnbs_pick_osc(osc_select_source_in, dly_b[dnbs_pkg::SEL_DELAY_CYC-1],
                              chan_b_osc_select_field_in);
        next_phase_a = acc_phase[0][sel_a];
        next_phase_b = acc_phase[1][sel_b];
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            chan_a_phase_out <= dnbs_pkg::ACC_RESET;
            chan_b_phase_out <= dnbs_pkg::ACC_RESET;
            chan_a_active_osc_out <= dnbs_pkg::SEL_RESET;
            chan_b_active_osc_out <= dnbs_pkg::SEL_RESET;
        end
        else
        begin
            chan_a_phase_out <= next_phase_a;
            chan_b_phase_out <= next_phase_b;
            chan_a_active_osc_out <= sel_a;
            chan_b_active_osc_out <= sel_b;
        end
    end

    assign nco_sync_out = sync_pulse;
    assign sync_armed_out = armed;

endmodule // dnbs_nco_bank

`default_nettype wire

// ---- dv/dnbs_nco_bank_sva.sv ----
// assertion checker for the oscillator bank ports
`timescale 1ns/1ps
`default_nettype none

module dnbs_nco_bank_chk (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // watched inputs
    input wire logic osc_select_source_in,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_a_osc_select_field_in,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_b_osc_select_field_in,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_a_osc_select_pins_in,
    input wire logic [dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::FREQ_W-1:0] chan_a_freq_word_in,
    input wire logic [dnbs_pkg::NUM_OSC-1:0][dnbs_pkg::PHASE_W-1:0] chan_a_phase_offset_in,
    input wire logic [dnbs_pkg::RDIV_W-1:0] rational_step_divisor_in,
    input wire logic sync_on_link_init_in,
    input wire logic sync_on_next_sysref_arm_in,
    input wire logic sysref_in,
    // watched outputs
    input wire logic [dnbs_pkg::FREQ_W-1:0] chan_a_phase_out,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_a_active_osc_out,
    input wire logic [dnbs_pkg::SEL_W-1:0] chan_b_active_osc_out,
    input wire logic nco_sync_out,
    input wire logic sync_armed_out
);
    logic [2:0] quiet;
    logic [5:0] pin_age;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    // cycles of unchanged settings, and of unchanged pins in pin mode
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            quiet <= 3'h0;
            pin_age <= 6'h00;
        end
        else
        begin
            if (!$stable(chan_a_freq_word_in) || !$stable(chan_a_phase_offset_in) || !$stable(chan_a_active_osc_out)
                || nco_sync_out || rational_step_divisor_in != dnbs_pkg::RDIV_BASIC)
                quiet <= 3'h0;
            else if (quiet != 3'h7)
                quiet <= quiet + 3'h1;
            if (!osc_select_source_in || !$stable(chan_a_osc_select_pins_in) || !$stable(osc_select_source_in))
                pin_age <= 6'h00;
            else if (pin_age != 6'h3f)
                pin_age <= pin_age + 6'h01;
        end
    end

    property p_field_sel;
        !osc_select_source_in |=> chan_a_active_osc_out == $past(chan_a_osc_select_field_in)
            && chan_b_active_osc_out == $past(chan_b_osc_select_field_in);
    endproperty
    a_field_sel: assert property (p_field_sel) else $error("field select not followed");

    property p_pin_sel;
        pin_age >= 6'd42 |-> chan_a_active_osc_out == chan_a_osc_select_pins_in;
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("pin select not followed");

    property p_basic_step;
        quiet >= 3'h4 && $stable(chan_a_active_osc_out) && $stable(chan_a_freq_word_in)
            |-> chan_a_phase_out - $past(chan_a_phase_out) == chan_a_freq_word_in[chan_a_active_osc_out];
    endproperty
    a_basic_step: assert property (p_basic_step) else $error("phase step differs from word");

    property p_arm;
        $rose(sync_on_next_sysref_arm_in) |=> sync_armed_out;
    endproperty
    a_arm: assert property (p_arm) else $error("arm write did not arm");

    property p_sysref_sync;
        sync_armed_out && !sync_on_link_init_in && !sysref_in ##1 sysref_in |-> ##[1:4] nco_sync_out;
    endproperty
    a_sysref_sync: assert property (p_sysref_sync) else $error("armed sysref edge gave no sync");

    property p_no_unarmed;
        (!sync_armed_out && !sync_on_link_init_in) [*4] |-> !nco_sync_out;
    endproperty
    a_no_unarmed: assert property (p_no_unarmed) else $error("sync without arming");

    property p_one_pulse;
        nco_sync_out |=> !nco_sync_out;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("sync pulse too long");

    property p_after_sync;
        nco_sync_out |-> ##2 chan_a_phase_out == {chan_a_phase_offset_in[chan_a_active_osc_out], 16'h0000};
    endproperty
    a_after_sync: assert property (p_after_sync) else $error("phase after sync not offset");

    c_sysref: cover property (nco_sync_out && !sync_on_link_init_in);
    c_link: cover property (nco_sync_out && sync_on_link_init_in);
    c_pins: cover property (pin_age == 6'd42);
endmodule // dnbs_nco_bank_chk

bind dnbs_nco_bank dnbs_nco_bank_chk u_chk (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .osc_select_source_in(osc_select_source_in),
    .chan_a_osc_select_field_in(chan_a_osc_select_field_in), .chan_b_osc_select_field_in(chan_b_osc_select_field_in),
    .chan_a_osc_select_pins_in(chan_a_osc_select_pins_in), .chan_a_freq_word_in(chan_a_freq_word_in),
    .chan_a_phase_offset_in(chan_a_phase_offset_in), .rational_step_divisor_in(rational_step_divisor_in),
    .sync_on_link_init_in(sync_on_link_init_in), .sync_on_next_sysref_arm_in(sync_on_next_sysref_arm_in),
    .sysref_in(sysref_in), .chan_a_phase_out(chan_a_phase_out), .chan_a_active_osc_out(chan_a_active_osc_out),
    .chan_b_active_osc_out(chan_b_active_osc_out), .nco_sync_out(nco_sync_out), .sync_armed_out(sync_armed_out)
);
`default_nettype wire

// ---- dv/dnbs_far_end.sv ----
// far-side model: link receiver sync pins and sysref source
`timescale 1ns/1ps
`default_nettype none

module dnbs_far_end (
    // clock
    input wire logic sys_clk_in,
    // which sync pin is wired
    input wire logic use_diff_in,
    // pins
    output logic single_ended_sync_out,
    output logic differential_sync_out,
    output logic sysref_out
);
    logic sync_lvl = 1'b1;
    logic idle_tgl = 1'b0;
    logic [2:0] hold = 3'h0;

    initial sysref_out = 1'b0;
    // unused sync pin toggles so a wrong pick shows
    assign single_ended_sync_out = use_diff_in ? idle_tgl : sync_lvl;
    assign differential_sync_out = use_diff_in ? sync_lvl : idle_tgl;

    always @(posedge sys_clk_in)
    begin
        idle_tgl <= ~idle_tgl;
        if (hold != 3'h0)
        begin
            hold <= hold - 3'h1;
            if (hold == 3'h1)
                sysref_out <= 1'b0;
        end
    end

    // all converters see the same release edge
    task automatic set_sync(input logic lvl);
        sync_lvl <= lvl;
    endtask

    // one pulse, low before and after, fixed to the clock grid
    task automatic pulse_sysref();
        sysref_out <= 1'b1;
        hold <= 3'h4;
    endtask
endmodule // dnbs_far_end
`default_nettype wire

// ---- dv/ddc_nco_bank_sync_bench.sv ----
// self-checking bench for the oscillator bank
`timescale 1ns/1ps
`default_nettype none

module ddc_nco_bank_sync_bench;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic source = 1'b0, link_init = 1'b0, arm = 1'b0, link_en = 1'b0, diff_sel = 1'b0;
    logic [1:0] fld_a = 2'h0, fld_b = 2'h0, pins_a = 2'h0, pins_b = 2'h0, act_a, act_b;
    logic [3:0][31:0] freq_a, freq_b;
    logic [3:0][15:0] off_a, off_b;
    logic [15:0] rdiv = 16'h0000;
    logic se_pin, diff_pin, sysref, nco_sync, armed;
    logic [31:0] ph_a, ph_b;
    int error_cnt = 0;
    int n_compared = 0;

    initial forever #12.5 sys_clk_in = ~sys_clk_in;

    dnbs_nco_bank u_dut (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .osc_select_source_in(source),
        .chan_a_osc_select_field_in(fld_a), .chan_b_osc_select_field_in(fld_b),
        .chan_a_osc_select_pins_in(pins_a), .chan_b_osc_select_pins_in(pins_b),
        .chan_a_freq_word_in(freq_a), .chan_b_freq_word_in(freq_b), .chan_a_phase_offset_in(off_a),
        .chan_b_phase_offset_in(off_b), .rational_step_divisor_in(rdiv), .sync_on_link_init_in(link_init),
        .sync_on_next_sysref_arm_in(arm), .serial_link_enable_in(link_en), .sync_input_is_differential_in(diff_sel),
        .single_ended_sync_input_in(se_pin), .differential_sync_input_in(diff_pin), .sysref_in(sysref),
        .chan_a_phase_out(ph_a), .chan_b_phase_out(ph_b), .chan_a_active_osc_out(act_a),
        .chan_b_active_osc_out(act_b), .nco_sync_out(nco_sync), .sync_armed_out(armed)
    );

    dnbs_far_end u_far (
        .sys_clk_in(sys_clk_in), .use_diff_in(diff_sel), .single_ended_sync_out(se_pin),
        .differential_sync_out(diff_pin), .sysref_out(sysref)
    );

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic wait_sync();
        for (int i = 0; i < 12; i++)
        begin
            tick(1);
            if (nco_sync === 1'b1)
                return;
        end
        error_cnt++;
        report_and_stop();
    endtask

    task automatic no_sync(input int n);
        repeat (n)
        begin
            tick(1);
            check(nco_sync, 0);
        end
    endtask

    task automatic post_sync(input int s);
        tick(2);
        check(ph_a, {off_a[s], 16'h0000});
        tick(1);
        check(ph_a, freq_a[s] + {off_a[s], 16'h0000});
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_field();
        logic [31:0] p0, pb;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk_in);
            fld_a <= i[1:0];
            fld_b <= 2'(3 - i);
            tick(3);
            check(act_a, i);
            check(act_b, 3 - i);
            p0 = ph_a;
            pb = ph_b;
            tick(1);
            check(ph_a - p0, freq_a[i]);
            check(ph_b - pb, freq_b[3 - i]);
        end
    endtask

    task automatic t_pins();
        @(posedge sys_clk_in);
        fld_a <= 2'h3;
        source <= 1'b1;
        pins_a <= 2'h2;
        pins_b <= 2'h1;
        tick(30);
        check(act_a, 0);
        tick(15);
        check(act_a, 2);
        check(act_b, 1);
        @(posedge sys_clk_in);
        source <= 1'b0;
        fld_a <= 2'h1;
    endtask

    task automatic t_sysref();
        @(posedge sys_clk_in);
        u_far.pulse_sysref();
        no_sync(10);
        @(posedge sys_clk_in);
        arm <= 1'b1;
        tick(2);
        check(armed, 1);
        @(posedge sys_clk_in);
        u_far.pulse_sysref();
        wait_sync();
        check(armed, 0);
        post_sync(1);
        @(posedge sys_clk_in);
        fld_a <= 2'h2;
        tick(1);
        check(ph_a, 3 * freq_a[2] + {off_a[2], 16'h0000});
    endtask

    task automatic t_link(input logic d);
        @(posedge sys_clk_in);
        diff_sel <= d;
        link_init <= 1'b1;
        link_en <= 1'b0;
        fld_a <= 2'h1;
        u_far.set_sync(1'b1);
        repeat (4) @(posedge sys_clk_in);
        link_en <= 1'b1;
        @(posedge sys_clk_in);
        u_far.set_sync(1'b0);
        no_sync(10);
        @(posedge sys_clk_in);
        u_far.set_sync(1'b1);
        wait_sync();
        post_sync(1);
        @(posedge sys_clk_in);
        link_en <= 1'b0;
        link_init <= 1'b0;
    endtask

    task automatic t_rational();
        @(posedge sys_clk_in);
        rdiv <= 16'h0780;
        freq_a[1] <= 32'h0000_8889;
        arm <= 1'b0;
        @(posedge sys_clk_in);
        arm <= 1'b1;
        tick(2);
        @(posedge sys_clk_in);
        u_far.pulse_sysref();
        wait_sync();
        tick(2);
        check(ph_a, {off_a[1], 16'h0000});
        tick(1920);
        check(ph_a, 32'h0400_0000 + {off_a[1], 16'h0000});
    endtask

    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            freq_a[i] = 32'h1111_0000 * (i + 1) + 32'h0000_0123;
            freq_b[i] = 32'h0202_0000 * (i + 1);
            off_a[i] = 16'h2000 * i + 16'h0010;
            off_b[i] = 16'h0400 * i;
        end
        repeat (16) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        tick(2);
        check(armed, 0);
        t_field();
        t_pins();
        t_sysref();
        t_link(1'b0);
        t_link(1'b1);
        t_rational();
        report_and_stop();
    end
endmodule // ddc_nco_bank_sync_bench
`default_nettype wire
